// File: rtl/ivp_map.sv
/*
  Interrupt vector and priority map with its Avalon-MM register slave.
  Assumes one core clock, synchronous active-low reset shared with the
  core, peripheral pulses on the same clock and asynchronous pins.
*/
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ns

module ivp_map (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic reset_request_n_in,
  input wire logic nmi_n_in,
  input wire logic ext_user_irq_a_n_in,
  input wire logic ext_user_irq_b_n_in,
  input wire logic ext_user_irq_c_n_in,
  input wire logic ext_user_irq_d_n_in,
  input wire logic timer_irq_in,
  input wire logic serial_port_a_rx_irq_in,
  input wire logic serial_port_a_tx_irq_in,
  input wire logic serial_port_b_rx_irq_in,
  input wire logic serial_port_b_tx_irq_in,
  input wire logic serial_port_c_rx_irq_in,
  input wire logic serial_port_c_tx_irq_in,
  input wire logic host_port_irq_in,
  input wire logic dma_chan_e_irq_in,
  input wire logic dma_chan_f_irq_in,
  input wire logic core_irq_ack_in,
  input wire logic core_trap_req_in,
  input wire logic [4:0] core_trap_num_in,
  output logic core_irq_req_out,
  output logic [4:0] core_vec_num_out,
  output logic [15:0] core_vec_addr_out,
  output logic [15:0] core_trap_addr_out,
  output logic core_trap_bad_out,
  output logic core_trap_done_out,
  output logic irq_out,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int unsigned NW = ivp_pkg::NUM_W;
  localparam int unsigned AW = ivp_pkg::ADDR_W;
  localparam int unsigned RW = ivp_pkg::REG_W;
  localparam int unsigned SC = ivp_pkg::SRC_COUNT;
  localparam int unsigned PC = ivp_pkg::PIN_COUNT;
  localparam int unsigned TS = ivp_pkg::TABLE_SHIFT;

  logic [PC-1:0] pin_meta_r;
  logic [PC-1:0] pin_sync_r;
  logic [PC-1:0] pin_prev_r;
  logic [PC-1:0] pin_fall;
  logic [PC-1:0] pin_raw;

  logic [RW-1:0] flag_r;
  logic [RW-1:0] flag_nxt;
  logic [RW-1:0] mask_r;
  logic [RW-1:0] mask_nxt;
  logic [AW-1:0] base_r;
  logic [AW-1:0] base_nxt;
  logic reset_pend_r;
  logic reset_pend_nxt;
  logic nmi_pend_r;
  logic nmi_pend_nxt;

  logic [RW-1:0] src_set;
  logic [RW-1:0] flag_clr;
  logic [RW-1:0] ack_clr;
  logic [RW-1:0] live;
  logic [RW-1:0] lane_mask;
  logic any_live;
  logic [NW-1:0] live_num;

  ivp_pkg::ivp_vec_type sel;
  ivp_pkg::ivp_vec_type vec_r;

  logic bus_ack_r;
  logic bus_req;
  logic wr_take;
  logic rd_take;
  logic sel_flag;
  logic sel_mask;
  logic sel_base;
  logic sel_trap;
  logic sel_vec;
  logic [31:0] rd_mux;
  logic [31:0] rdata_r;

  logic soft_reset_trap;
  logic soft_trap_sixteen;
  logic ack_reset;
  logic ack_nmi;
  logic ack_hw;

  logic [AW-1:0] trap_addr_r;
  logic trap_bad_r;
  logic trap_done_r;
  logic trap_bad;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Pins are active low; an interrupt is a falling edge on the pin.
  assign pin_raw = {nmi_n_in,
                    reset_request_n_in,
                    ext_user_irq_d_n_in,
                    ext_user_irq_c_n_in,
                    ext_user_irq_b_n_in,
                    ext_user_irq_a_n_in};

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_meta_r <= '1;
      pin_sync_r <= '1;
      pin_prev_r <= '1;
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  // Edge detection reads only the second and third stages.
  assign pin_fall = pin_prev_r & ~pin_sync_r;

  // ----------------------------------------------------------------
  // Source to flag bit map
  // ----------------------------------------------------------------
  // Software-only numbers have no source bit.
  // Shared layout, sources ascend from bit 0.
  assign src_set[0] = pin_fall[0];
  assign src_set[1] = pin_fall[1];
  assign src_set[2] = pin_fall[2];
  assign src_set[3] = timer_irq_in;
  assign src_set[4] = serial_port_a_rx_irq_in;
  assign src_set[5] = serial_port_a_tx_irq_in;
  assign src_set[6] = serial_port_c_rx_irq_in;
  assign src_set[7] = serial_port_c_tx_irq_in;
  assign src_set[8] = pin_fall[3];
  assign src_set[9] = host_port_irq_in;
  assign src_set[10] = serial_port_b_rx_irq_in;
  assign src_set[11] = serial_port_b_tx_irq_in;
  assign src_set[12] = dma_chan_e_irq_in;
  assign src_set[13] = dma_chan_f_irq_in;
  assign src_set[RW-1:SC] = '0;

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // Every access takes one wait state, so read data is always a flop.
  assign bus_req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = bus_req & ~bus_ack_r;
  assign wr_take = avs_write_in & bus_ack_r;
  assign rd_take = avs_read_in & ~bus_ack_r;

  assign sel_flag = (avs_address_in == ivp_pkg::OFS_FLAG);
  assign sel_mask = (avs_address_in == ivp_pkg::OFS_MASK);
  assign sel_base = (avs_address_in == ivp_pkg::OFS_BASE);
  assign sel_trap = (avs_address_in == ivp_pkg::OFS_TRAP);
  assign sel_vec = (avs_address_in == ivp_pkg::OFS_VEC);

  assign lane_mask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  // Unmapped addresses read zero and ignore writes.
  assign rd_mux = sel_flag ? {16'h0000, flag_r} :
                  sel_mask ? {16'h0000, mask_r} :
                  sel_base ? {16'h0000, base_r} :
                  sel_trap ? {30'h00000000, nmi_pend_r, reset_pend_r} :
                  sel_vec ? {vec_r.valid, 10'h000, vec_r.num, vec_r.addr} :
                  32'h00000000;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bus_ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      bus_ack_r <= bus_req & ~bus_ack_r;
      rdata_r <= rd_take ? rd_mux : rdata_r;
    end
  end

  assign avs_readdata_out = rdata_r;

  // ----------------------------------------------------------------
  // Flag, mask and base registers
  // ----------------------------------------------------------------
  assign soft_reset_trap = wr_take & sel_trap & avs_byteenable_in[0]
                           & avs_writedata_in[ivp_pkg::TRAP_BIT_RESET];
  assign soft_trap_sixteen = wr_take & sel_trap & avs_byteenable_in[0]
                             & avs_writedata_in[ivp_pkg::TRAP_BIT_NMI];

  // Writing a one clears a flag; a new event in the same cycle wins.
  assign flag_clr = (wr_take & sel_flag) ?
                    (avs_writedata_in[RW-1:0] & lane_mask) : '0;

  // Reserved bits hold zero in both registers.
  assign flag_nxt = ((flag_r & ~(flag_clr | ack_clr)) | src_set)
                    & ivp_pkg::FLAG_IMPL;

  assign mask_nxt = (wr_take & sel_mask) ?
                    (((mask_r & ~lane_mask) | (avs_writedata_in[RW-1:0] & lane_mask))
                     & ivp_pkg::FLAG_IMPL) : mask_r;

  // Base aligned to one whole table.
  assign base_nxt = (wr_take & sel_base) ?
                    {((base_r[AW-1:8] & ~{8{avs_byteenable_in[1]}})
                      | (avs_writedata_in[AW-1:8] & {8{avs_byteenable_in[1]}})),
                     (avs_byteenable_in[0] ? avs_writedata_in[7:TS] : base_r[7:TS]),
                     {TS{1'b0}}} : base_r;

  // Reset and nonmaskable pend apart from the flags.
  assign reset_pend_nxt = (reset_pend_r & ~ack_reset)
                          | pin_fall[ivp_pkg::PIN_RESET] | soft_reset_trap;
  assign nmi_pend_nxt = (nmi_pend_r & ~ack_nmi)
                        | pin_fall[ivp_pkg::PIN_NMI] | soft_trap_sixteen;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flag_r <= ivp_pkg::FLAG_RST;
      mask_r <= ivp_pkg::MASK_RST;
      base_r <= ivp_pkg::BASE_RST;
      reset_pend_r <= 1'b0;
      nmi_pend_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      mask_r <= mask_nxt;
      base_r <= base_nxt;
      reset_pend_r <= reset_pend_nxt;
      nmi_pend_r <= nmi_pend_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Priority selection
  // ----------------------------------------------------------------
  // Mask gates only the flag sources.
  assign live = flag_r & mask_r;
  assign any_live = |live;

  // Bit order equals priority order, so the lowest bit wins.
  // Smallest priority number first.
  always_comb begin
    live_num = ivp_pkg::NUM_HW_FIRST;
    for (int i = SC - 1; i >= 0; i--) begin
      if (live[i]) begin
        // Bit index plus sixteen gives the number.
        live_num = ivp_pkg::NUM_HW_FIRST + NW'(i);
      end
    end
  end

  // Reset outranks nonmaskable, both outrank the rest.
  always_comb begin
    sel.valid = reset_pend_r | nmi_pend_r | any_live;
    if (reset_pend_r) begin
      sel.num = ivp_pkg::NUM_RESET;
    end else if (nmi_pend_r) begin
      sel.num = ivp_pkg::NUM_NMI;
    end else begin
      sel.num = live_num;
    end
    // Four words per entry above the base.
    sel.addr = {base_r[AW-1:TS], sel.num, {ivp_pkg::ENTRY_SHIFT{1'b0}}};
  end

  // ----------------------------------------------------------------
  // Core vector port
  // ----------------------------------------------------------------
  // The acknowledge retires whatever the core was shown, even if a
  // higher source arrived in the same cycle; that one is shown next.
  assign ack_reset = core_irq_ack_in & vec_r.valid
                     & (vec_r.num == ivp_pkg::NUM_RESET);
  assign ack_nmi = core_irq_ack_in & vec_r.valid
                   & (vec_r.num == ivp_pkg::NUM_NMI);
  assign ack_hw = core_irq_ack_in & vec_r.valid
                  & (vec_r.num >= ivp_pkg::NUM_HW_FIRST);

  // Numbers up to 29 map back onto flag bits 0 to 13.
  always_comb begin
    ack_clr = '0;
    if (ack_hw) begin
      ack_clr[4'(vec_r.num - ivp_pkg::NUM_HW_FIRST)] = 1'b1;
    end
  end

  // The shown vector drops for one cycle after an acknowledge so the
  // core never sees a retired entry twice.
  // An idle port shows all zeros, never a stale number or address.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      vec_r <= '0;
    end else if (core_irq_ack_in || !sel.valid) begin
      vec_r <= '0;
    end else begin
      vec_r <= sel;
    end
  end

  assign core_irq_req_out = vec_r.valid;
  assign core_vec_num_out = vec_r.num;
  assign core_vec_addr_out = vec_r.addr;
  assign irq_out = any_live;

  // ----------------------------------------------------------------
  // Software trap lookup
  // ----------------------------------------------------------------
  // Numbers 30 and 31 are reserved.
  assign trap_bad = (core_trap_num_in > ivp_pkg::NUM_DEF_LAST);

  // Software traps carry no priority and bypass the flags.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      trap_addr_r <= '0;
      trap_bad_r <= 1'b0;
      trap_done_r <= 1'b0;
    end else begin
      trap_done_r <= core_trap_req_in;
      if (core_trap_req_in) begin
        trap_addr_r <= {base_r[AW-1:TS], core_trap_num_in,
                        {ivp_pkg::ENTRY_SHIFT{1'b0}}};
        trap_bad_r <= trap_bad;
      end
    end
  end

  assign core_trap_addr_out = trap_addr_r;
  assign core_trap_bad_out = trap_bad_r;
  assign core_trap_done_out = trap_done_r;

  // ----------------------------------------------------------------
  // Fixed map notes
  // ----------------------------------------------------------------
  // Bit 1, number 17, is external b.
  // Bits 2 and 3 are external c and timer.
  // Bit 4 is serial port a receive.
  // Bit 5 is serial port a transmit.
  // Bit 6 is serial port c receive.
  // Bit 7 is serial port c transmit.
  // Bits 8 and 9 are external d and host port.
  // Bit 10 is serial port b receive.
  // Bit 11 is serial port b transmit.
  // Bit 12 is DMA channel e.
  // The numbers follow from the bit positions through live_num.

endmodule : ivp_map

// File: rtl/ivp_pkg.sv
/*
  Package for the interrupt vector and priority map: register offsets,
  flag bit positions, trap numbers, reset values and the vector carrier.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package ivp_pkg;

  // ----------------------------------------------------------------
  // Trap numbers and vector geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_W = 5;
  localparam logic [4:0] NUM_RESET = 5'h00;
  localparam logic [4:0] NUM_NMI = 5'h01;
  localparam logic [4:0] NUM_SW_FIRST = 5'h02;
  localparam logic [4:0] NUM_SW_LAST = 5'h0F;
  localparam logic [4:0] NUM_HW_FIRST = 5'h10;
  localparam logic [4:0] NUM_DEF_LAST = 5'h1D;
  localparam int unsigned ENTRY_SHIFT = 2;
  localparam int unsigned TABLE_SHIFT = 7;
  localparam int unsigned ADDR_W = 16;

  // ----------------------------------------------------------------
  // Flag and mask layout
  // ----------------------------------------------------------------
  localparam int unsigned SRC_COUNT = 14;
  localparam int unsigned REG_W = 16;
  localparam logic [15:0] FLAG_IMPL = 16'h3FFF;
  localparam logic [15:0] FLAG_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam int unsigned PIN_COUNT = 6;
  localparam int unsigned PIN_RESET = 4;
  localparam int unsigned PIN_NMI = 5;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam int unsigned BUS_AW = 5;
  localparam logic [4:0] OFS_FLAG = 5'h00;
  localparam logic [4:0] OFS_MASK = 5'h04;
  localparam logic [4:0] OFS_BASE = 5'h08;
  localparam logic [4:0] OFS_TRAP = 5'h0C;
  localparam logic [4:0] OFS_VEC = 5'h10;
  localparam int unsigned TRAP_BIT_RESET = 0;
  localparam int unsigned TRAP_BIT_NMI = 1;
  localparam int unsigned VEC_NUM_LSB = 16;
  localparam int unsigned VEC_VALID_BIT = 31;

  // ----------------------------------------------------------------
  // Vector carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [4:0] num;
    logic [15:0] addr;
  } ivp_vec_type;

endpackage : ivp_pkg

// File: tb/ivp_map_properties.sv
/*
  Concurrent checks on the ports of the interrupt vector map.
  Assumes it is bound to ivp_map and sees only that module's ports.
*/
`timescale 1ns/1ns
module ivp_map_properties (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic reset_request_n_in,
  input wire logic nmi_n_in,
  input wire logic core_irq_ack_in,
  input wire logic core_trap_req_in,
  input wire logic [4:0] core_trap_num_in,
  input wire logic core_irq_req_out,
  input wire logic [4:0] core_vec_num_out,
  input wire logic [15:0] core_vec_addr_out,
  input wire logic [15:0] core_trap_addr_out,
  input wire logic core_trap_bad_out,
  input wire logic core_trap_done_out,
  input wire logic irq_out,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out
);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence rst_fall_s; $fell(reset_request_n_in); endsequence
  sequence nmi_fall_s; $fell(nmi_n_in); endsequence
  sequence take_s; core_irq_req_out && core_irq_ack_in; endsequence
  sequence bus_wait_s; (avs_read_in || avs_write_in) && avs_waitrequest_out; endsequence
  vec_align_a: assert property (
    core_irq_req_out |-> core_vec_addr_out[6:0] == {core_vec_num_out, 2'h0})
    else $error("vector address does not match its number");
  trap_step_a: assert property (
    core_trap_req_in |=> core_trap_done_out &&
      core_trap_addr_out[6:0] == {$past(core_trap_num_in), 2'h0})
    else $error("trap lookup answer wrong");
  trap_bad_a: assert property (
    core_trap_req_in |=> core_trap_bad_out == ($past(core_trap_num_in) > 5'h1D))
    else $error("reserved trap flag wrong");
  no_soft_a: assert property (
    core_irq_req_out |-> core_vec_num_out < 5'h02 ||
      (core_vec_num_out >= 5'h10 && core_vec_num_out <= 5'h1D))
    else $error("hardware request shows a software number");
  reset_pin_a: assert property (
    rst_fall_s |-> ##[1:8] (core_irq_req_out && core_vec_num_out == 5'h00))
    else $error("reset pin not presented as number zero");
  nmi_pin_a: assert property (
    nmi_fall_s |-> ##[1:8] (core_irq_req_out && core_vec_num_out < 5'h02))
    else $error("nonmaskable pin not presented");
  unmasked_a: assert property (
    core_irq_req_out && core_vec_num_out >= 5'h10 |-> $past(irq_out))
    else $error("masked source presented to the core");
  take_retire_a: assert property (
    take_s |=> !core_irq_req_out)
    else $error("taken vector not retired");
  one_wait_a: assert property (
    bus_wait_s |=> !avs_waitrequest_out)
    else $error("register access not answered after one wait");
  flag_rsv_a: assert property (
    avs_read_in && !avs_waitrequest_out && avs_address_in < 5'h08
      |-> avs_readdata_out[31:14] == 18'h0)
    else $error("reserved flag or mask bits read nonzero");
endmodule : ivp_map_properties

bind ivp_map ivp_map_properties chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .reset_request_n_in(reset_request_n_in), .nmi_n_in(nmi_n_in),
  .core_irq_ack_in(core_irq_ack_in), .core_trap_req_in(core_trap_req_in),
  .core_trap_num_in(core_trap_num_in), .core_irq_req_out(core_irq_req_out),
  .core_vec_num_out(core_vec_num_out), .core_vec_addr_out(core_vec_addr_out),
  .core_trap_addr_out(core_trap_addr_out), .core_trap_bad_out(core_trap_bad_out),
  .core_trap_done_out(core_trap_done_out), .irq_out(irq_out),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out));

// File: tb/ivp_core_model.sv
/*
  Behavioural core side of the vector handshake: acks a shown vector after
  a chosen delay and reports what it took. Assumes the map's clock and reset.
*/
`timescale 1ns/1ns
module ivp_core_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  input wire logic [3:0] delay_in,
  input wire logic req_in,
  input wire logic [4:0] num_in,
  input wire logic [15:0] addr_in,
  output logic ack_out = 1'h0,
  output logic took_out = 1'h0,
  output logic [4:0] took_num_out = 5'h00,
  output logic [15:0] took_addr_out = 16'h0000
);
  logic [3:0] wait_r = 4'h0;
  // ----------------------------------------------------------------
  // Ack handshake
  // ----------------------------------------------------------------
  // The ack lasts one cycle, so one shown vector is never taken twice.
  always @(posedge clk_in) begin
    took_out <= 1'h0;
    if (!rst_n_in || !en_in) begin
      ack_out <= 1'h0;
      wait_r <= 4'h0;
    end else if (ack_out) begin
      ack_out <= 1'h0;
      wait_r <= 4'h0;
      took_out <= req_in;
      took_num_out <= num_in;
      took_addr_out <= addr_in;
    end else if (req_in && wait_r >= delay_in) begin
      ack_out <= 1'h1;
    end else if (req_in) begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule : ivp_core_model

// File: tb/ivp_map_tb_top.sv
/*
  Self-checking bench for the interrupt vector map: register bus tasks,
  trap lookups and source scenarios. Assumes the core model beside it.
*/
`timescale 1ns/1ns
module ivp_map_tb_top;
  localparam logic [15:0] BASE = 16'h1280;
  logic clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic reset_request_n_in = 1'h1;
  logic nmi_n_in = 1'h1;
  logic [13:0] hw = 14'h0000;
  wire ext_user_irq_a_n_in = !hw[0];
  wire ext_user_irq_b_n_in = !hw[1];
  wire ext_user_irq_c_n_in = !hw[2];
  wire timer_irq_in = hw[3];
  wire serial_port_a_rx_irq_in = hw[4];
  wire serial_port_a_tx_irq_in = hw[5];
  wire serial_port_c_rx_irq_in = hw[6];
  wire serial_port_c_tx_irq_in = hw[7];
  wire ext_user_irq_d_n_in = !hw[8];
  wire host_port_irq_in = hw[9];
  wire serial_port_b_rx_irq_in = hw[10];
  wire serial_port_b_tx_irq_in = hw[11];
  wire dma_chan_e_irq_in = hw[12];
  wire dma_chan_f_irq_in = hw[13];
  wire core_irq_ack_in;
  logic core_trap_req_in = 1'h0;
  logic [4:0] core_trap_num_in = 5'h00;
  logic core_irq_req_out, core_trap_bad_out, core_trap_done_out, irq_out;
  logic [4:0] core_vec_num_out;
  logic [15:0] core_vec_addr_out, core_trap_addr_out;
  logic [4:0] avs_address_in = 5'h00;
  logic avs_read_in = 1'h0;
  logic avs_write_in = 1'h0;
  logic [31:0] avs_writedata_in = 32'h0;
  wire [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic en = 1'h0;
  logic [3:0] dly = 4'h3;
  logic took;
  logic [4:0] tnum;
  logic [15:0] taddr;
  logic [4:0] qn[$];
  logic [15:0] qa[$];
  int err_count = 0;
  int checks_done = 0;

  ivp_map dut_u (.*);
  ivp_core_model core_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .en_in(en),
    .delay_in(dly), .req_in(core_irq_req_out), .num_in(core_vec_num_out),
    .addr_in(core_vec_addr_out), .ack_out(core_irq_ack_in), .took_out(took),
    .took_num_out(tnum), .took_addr_out(taddr));

  always #4 clk_in = !clk_in;
  always @(posedge clk_in) begin
    if (took === 1'h1) begin
      qn.push_back(tnum);
      qa.push_back(taddr);
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The request stays put until waitrequest is seen low, then one idle edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n = 0;
    avs_address_in <= a;
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_writedata_in <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'h0 && n < 50);
    if (n >= 50) begin
      err_count++;
      give_verdict();
    end else begin
      q = avs_readdata_out;
      avs_read_in <= 1'h0;
      avs_write_in <= 1'h0;
      @(posedge clk_in);
    end
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(q, e);
  endtask : rd

  task automatic take(input logic [4:0] k);
    int n;
    for (n = 0; n < 300 && qn.size() == 0; n++) @(posedge clk_in);
    if (qn.size() == 0) begin
      err_count++;
      give_verdict();
    end else begin
      chk(qn.pop_front(), k);
      chk(qa.pop_front(), {BASE[15:7], k, 2'h0});
    end
  endtask : take

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    int i;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'h1;
    @(posedge clk_in);
    for (i = 0; i < 24; i += 4) rd(5'(i), 32'h0);
    wr(ivp_pkg::OFS_MASK, 32'hFFFF);
    rd(ivp_pkg::OFS_MASK, 32'h3FFF);
    wr(ivp_pkg::OFS_BASE, 32'hFFFF);
    rd(ivp_pkg::OFS_BASE, 32'hFF80);
    wr(ivp_pkg::OFS_BASE, {16'h0, BASE});
    wr(5'h14, 32'hFFFF);
    rd(5'h14, 32'h0);
    wr(ivp_pkg::OFS_MASK, 32'h0);
    for (i = 0; i < 34; i++) begin
      if (i >= 2) begin
        chk(core_trap_done_out, 1'h1);
        chk(core_trap_addr_out, {BASE[15:7], 5'(i - 2), 2'h0});
        chk(core_trap_bad_out, i - 2 > 29);
      end
      core_trap_req_in <= i < 32;
      core_trap_num_in <= 5'(i);
      @(posedge clk_in);
    end
    hw <= 14'h0008;
    @(posedge clk_in);
    hw <= 14'h0000;
    repeat (3) @(posedge clk_in);
    chk(irq_out, 1'h0);
    rd(ivp_pkg::OFS_FLAG, 32'h0008);
    wr(ivp_pkg::OFS_MASK, 32'h0008);
    chk(irq_out, 1'h1);
    rd(ivp_pkg::OFS_VEC, 32'h801312CC);
    wr(ivp_pkg::OFS_FLAG, 32'h0008);
    chk(irq_out, 1'h0);
    rd(ivp_pkg::OFS_FLAG, 32'h0);
    // Pins reach the flags two edges later than the pulses, so they lead.
    wr(ivp_pkg::OFS_MASK, 32'h3FFF);
    en <= 1'h1;
    hw <= 14'h0107;
    repeat (2) @(posedge clk_in);
    hw <= 14'h3FFF;
    @(posedge clk_in);
    hw <= 14'h0107;
    for (i = 16; i < 23; i++) take(5'(i));
    for (i = 23; i < 30; i++) take(5'(i));
    hw <= 14'h0000;
    dly <= 4'h0;
    wr(ivp_pkg::OFS_MASK, 32'h0);
    reset_request_n_in <= 1'h0;
    nmi_n_in <= 1'h0;
    take(5'h00);
    take(5'h01);
    reset_request_n_in <= 1'h1;
    nmi_n_in <= 1'h1;
    wr(ivp_pkg::OFS_TRAP, 32'h1);
    take(5'h00);
    wr(ivp_pkg::OFS_TRAP, 32'h2);
    take(5'h01);
    give_verdict();
  end
endmodule : ivp_map_tb_top
